// >>> include/audio_in_pkg.sv
// audio input serial port: shared constants, carriers and decoders
// assumes: 24-bit sample path, 3-bit format straps, 64fs master clocks
package audio_in_pkg;

   // -------------------------------------------------------------
   // widths and counts
   // -------------------------------------------------------------
   localparam int SAMPLE_W = 24;                // widest word carried
   localparam logic [4:0] WORD_MAX = 5'h18;     // 24 bits per half frame
   localparam int FIFO_DEPTH = 4;               // pairs buffered
   localparam logic [5:0] MASTER_HALF = 6'h20;  // 32 bit clocks per half
   localparam logic [7:0] REF_HALF_BCLK = 8'h01; // ref cycles per bclk half
   localparam logic [4:0] LEN_16 = 5'h10;
   localparam logic [4:0] LEN_18 = 5'h12;
   localparam logic [4:0] LEN_20 = 5'h14;
   localparam logic [4:0] LEN_24 = 5'h18;

   // -------------------------------------------------------------
   // format select codes
   // -------------------------------------------------------------
   localparam logic [2:0] FMT_LJ24 = 3'h0;
   localparam logic [2:0] FMT_I2S24 = 3'h1;
   localparam logic [2:0] FMT_RJ16 = 3'h4;
   localparam logic [2:0] FMT_RJ18 = 3'h5;
   localparam logic [2:0] FMT_RJ20 = 3'h6;
   localparam logic [2:0] FMT_RJ24 = 3'h7;

   // -------------------------------------------------------------
   // types
   // -------------------------------------------------------------
   typedef enum {FR_LJ, FR_I2S, FR_RJ, FR_BAD} framing_t;
   typedef enum {H_IDLE, H_FULL} hold_state_t;

   typedef struct packed {
      logic [SAMPLE_W-1:0] left;
      logic [SAMPLE_W-1:0] right;
   } stereo_pair_t;

   typedef struct packed {
      logic bypass;          // pair goes around the converter
      stereo_pair_t pair;
   } rx_word_t;

   typedef struct packed {
      logic [2:0] fmt;
      logic in_master;
      logic out_master;
      logic bypass;
   } strap_t;

   // framing family of a format code
   function automatic framing_t decode_fmt(input logic [2:0] f);
      case (f)
         FMT_LJ24: decode_fmt = FR_LJ;
         FMT_I2S24: decode_fmt = FR_I2S;
         FMT_RJ16, FMT_RJ18, FMT_RJ20, FMT_RJ24: decode_fmt = FR_RJ;
         default: decode_fmt = FR_BAD;
      endcase
   endfunction

   // right-justified word length of a format code
   function automatic logic [4:0] rj_len(input logic [2:0] f);
      case (f)
         FMT_RJ16: rj_len = LEN_16;
         FMT_RJ18: rj_len = LEN_18;
         FMT_RJ20: rj_len = LEN_20;
         default: rj_len = LEN_24;
      endcase
   endfunction

endpackage

// >>> rtl/audio_in_fifo.sv
// small first-word-fall-through fifo with valid/ready on both sides
// assumes: one clock, depth a power of two
`timescale 1ns/10ps
module audio_in_fifo #(
   parameter int W = 49,
   parameter int DEPTH = 4
) (
   input logic core_clk,
   input logic rst,
   input logic in_valid,
   output logic in_ready,
   input logic [W-1:0] in_data,
   output logic out_valid,
   input logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem_q [DEPTH];  // storage words
   logic [AW:0] wr_q;             // write pointer, extra wrap bit
   logic [AW:0] wr_d;
   logic [AW:0] rd_q;             // read pointer, extra wrap bit
   logic [AW:0] rd_d;
   logic push;
   logic pop;

   // flags and pointer advance
   always_comb begin
      in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
      out_valid = wr_q != rd_q;
      push = in_valid & in_ready;
      pop = out_valid & out_ready;
      wr_d = wr_q + (AW+1)'(push);
      rd_d = rd_q + (AW+1)'(pop);
      out_data = mem_q[rd_q[AW-1:0]];
   end

   // pointers reset, storage does not need to
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
      end
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data;
      end
   end

   fill_bound_a: assert property (@(posedge core_clk) disable iff (rst)
      (wr_q - rd_q) <= (AW+1)'(DEPTH))
      else $error("fifo fill level above depth");
endmodule

// >>> rtl/audio_in_clkgen.sv
// master clock generator for the input port, on the reference clock
// assumes: reference clock at 128fs; reset and enable arrive unsynchronised
`timescale 1ns/10ps
module audio_in_clkgen
   import audio_in_pkg::*;
(
   input logic reference_clock_in,
   input logic rst,
   input logic master_en,
   output logic bit_clock_o,
   output logic word_clock_o,
   output logic clocks_oe
);
   logic rst_s1_q;     // reset synchroniser, first stage
   logic rst_s2_q;
   logic en_s1_q;      // enable synchroniser, first stage
   logic en_s2_q;
   logic [7:0] div_q;  // ref cycles within a bclk half
   logic [7:0] div_d;
   logic [5:0] bit_q;  // bit position in the 64-bit frame
   logic [5:0] bit_d;
   logic bclk_q;
   logic bclk_d;
   logic wclk_q;
   logic wclk_d;
   logic oe_q;
   logic oe_d;

   // -------------------------------------------------------------
   // divider: bclk at 64fs, word clock square at fs
   // -------------------------------------------------------------
   always_comb begin
      div_d = div_q;
      bclk_d = bclk_q;
      bit_d = bit_q;
      wclk_d = wclk_q;
      oe_d = en_s2_q;
      if (!en_s2_q) begin
         // parked low while slave
         div_d = '0;
         bclk_d = 1'b0;
         bit_d = '0;
         wclk_d = 1'b0;
      end else if (div_q == REF_HALF_BCLK - 8'h01) begin
         div_d = '0;
         bclk_d = ~bclk_q;
         if (bclk_q) begin
            // word clock moves on the falling edge, where data launches
            bit_d = bit_q + 6'h01;
            wclk_d = bit_d >= MASTER_HALF;
         end
      end else begin
         div_d = div_q + 8'h01;
      end
   end

   // registers; sync stages carry no reset of their own
   always_ff @(posedge reference_clock_in) begin
      rst_s1_q <= rst;
      rst_s2_q <= rst_s1_q;
      en_s1_q <= master_en;
      en_s2_q <= en_s1_q;
      if (rst_s2_q) begin
         div_q <= '0;
         bit_q <= '0;
         bclk_q <= 1'b0;
         wclk_q <= 1'b0;
         oe_q <= 1'b0;
      end else begin
         div_q <= div_d;
         bit_q <= bit_d;
         bclk_q <= bclk_d;
         wclk_q <= wclk_d;
         oe_q <= oe_d;
      end
   end

   assign bit_clock_o = bclk_q;
   assign word_clock_o = wclk_q;
   assign clocks_oe = oe_q;

   duty_split_a: assert property (@(posedge reference_clock_in) disable iff (rst_s2_q)
      $changed(wclk_q) && oe_q |-> bit_q[4:0] == 5'h00 && !bclk_q)
      else $error("word clock edge off the half-frame boundary");

   bclk_rate_a: assert property (@(posedge reference_clock_in) disable iff (rst_s2_q)
      en_s2_q && oe_q && $changed(bclk_q) |=> div_q == 8'h00)
      else $error("bit clock toggled off the divider wrap");
endmodule

// >>> rtl/audio_input_serial_port.sv
// input serial audio port: i2s / left / right justified receiver
// assumes: straps static in use; pair_ready from core-clock logic;
// the pin wires of bit and word clock read back what is driven
`timescale 1ns/10ps

// Overview of operation
// - three-wire receiver, slave or master selectable
// - i2s, left or right justified framing
// - master drives bit clock at 64fs
// - word clock at fs, in or out
// - master word clock has 50 percent duty
// - three-bit format select from straps
// - master clocks come from reference clock
// - at most one port is master
// - bypass forwards words unchanged to output
// - decode codes; 010 and 011 unused
module audio_input_serial_port
   import audio_in_pkg::*;
(
   input logic core_clk,
   input logic rst,
   input logic input_bit_clock,
   output logic input_bit_clock_o,
   output logic input_bit_clock_oe,
   input logic input_word_clock,
   output logic input_word_clock_o,
   output logic input_word_clock_oe,
   input logic serial_audio_in,
   input logic reference_clock_in,
   input logic [2:0] input_format_select,
   input logic input_master_sel,
   input logic output_master_sel,
   input logic bypass_sel,
   input logic pair_ready,
   output stereo_pair_t pair_data,
   output logic conv_valid,
   output logic bypass_valid,
   output logic master_conflict,
   output logic format_unused,
   output logic overrun
);

   // -------------------------------------------------------------
   // declarations, core clock domain
   // -------------------------------------------------------------
   strap_t strap_s1_q;          // strap synchroniser, first stage
   strap_t strap_q;             // straps as the core sees them
   logic in_master_q;           // input port runs master
   logic in_master_d;
   logic conflict_q;            // both ports asked for master
   logic conflict_d;
   logic unused_q;              // format code has no meaning
   logic unused_d;
   logic tog_s1_q;              // frame toggle, first stage
   logic tog_s2_q;
   logic tog_s3_q;              // previous value for edge detect
   hold_state_t hold_q;         // crossing holding register state
   hold_state_t hold_d;
   rx_word_t hold_word_q;       // pair waiting to enter the fifo
   rx_word_t hold_word_d;
   logic overrun_q;             // sticky: a pair was dropped
   logic overrun_d;
   logic new_frame;
   logic fifo_in_ready;
   logic fifo_out_valid;
   rx_word_t fifo_out;
   stereo_pair_t pair_q;
   stereo_pair_t pair_d;
   logic conv_valid_q;
   logic conv_valid_d;
   logic bypass_valid_q;
   logic bypass_valid_d;
   logic fire;

   // -------------------------------------------------------------
   // declarations, link (bit clock) domain
   // -------------------------------------------------------------
   logic lrst_s1_q;             // reset into link domain, first stage
   logic lrst_q;
   logic [2:0] lfmt_s1_q;       // format straps, first stage
   logic [2:0] lfmt_q;
   framing_t fr;                // framing family in force
   logic prev_wclk_q;           // word clock at the previous bit
   logic [23:0] sr_q;           // serial shift register
   logic [23:0] sr_d;
   logic [4:0] cnt_q;           // bits taken this half, saturates
   logic [4:0] cnt_d;
   logic [23:0] left_q;         // finished left word
   logic [23:0] left_d;
   logic have_left_q;           // left half seen this frame
   logic have_left_d;
   stereo_pair_t frame_q;       // last complete pair, held stable
   stereo_pair_t frame_d;
   logic tog_q;                 // flips once per complete pair
   logic tog_d;

   // -------------------------------------------------------------
   // strap synchronisers and mode decode, core domain
   // -------------------------------------------------------------
   always_comb begin
      // input side yields when both ask for master
      in_master_d = strap_q.in_master & ~strap_q.out_master;
      conflict_d = strap_q.in_master & strap_q.out_master;
      unused_d = decode_fmt(strap_q.fmt) == FR_BAD;
   end

   // two-stage capture of the strap pins
   always_ff @(posedge core_clk) begin
      strap_s1_q <= '{fmt: input_format_select, in_master: input_master_sel,
                      out_master: output_master_sel, bypass: bypass_sel};
      strap_q <= strap_s1_q;
      if (rst) begin
         in_master_q <= 1'b0;
         conflict_q <= 1'b0;
         unused_q <= 1'b0;
      end else begin
         in_master_q <= in_master_d;
         conflict_q <= conflict_d;
         unused_q <= unused_d;
      end
   end

   // -------------------------------------------------------------
   // master clock generation on the reference clock
   // -------------------------------------------------------------
   // drives bit and word clock pins only while master
   audio_in_clkgen u_clkgen (
      .reference_clock_in(reference_clock_in),
      .rst(rst),
      .master_en(in_master_q),
      .bit_clock_o(input_bit_clock_o),
      .word_clock_o(input_word_clock_o),
      .clocks_oe(input_bit_clock_oe)
   );
   assign input_word_clock_oe = input_bit_clock_oe;

   // -------------------------------------------------------------
   // link domain: synchronisers
   // -------------------------------------------------------------
   // the bit clock may stop, so reset and format are caught on it
   always_ff @(posedge input_bit_clock) begin
      lrst_s1_q <= rst;
      lrst_q <= lrst_s1_q;
      lfmt_s1_q <= input_format_select;
      lfmt_q <= lfmt_s1_q;
   end

   assign fr = decode_fmt(lfmt_q);

   // -------------------------------------------------------------
   // link domain: deserialiser
   // -------------------------------------------------------------
   // word clock is source-synchronous data here, sampled with serial_audio_in
   always_comb begin
      logic [23:0] sh;
      logic [23:0] wsrc;
      logic [4:0] n;
      logic [23:0] word;
      logic shift_en;
      logic left_half;
      sh = {sr_q[22:0], serial_audio_in};
      // right justified keeps shifting; the tail holds the word
      shift_en = (fr == FR_RJ) || (cnt_q < WORD_MAX);
      wsrc = sr_q;
      n = cnt_q;
      word = '0;
      left_half = 1'b0;
      sr_d = sr_q;
      cnt_d = cnt_q;
      left_d = left_q;
      have_left_d = have_left_q;
      frame_d = frame_q;
      tog_d = tog_q;
      if (fr == FR_BAD) begin
         // unused code: nothing is framed
         sr_d = '0;
         cnt_d = '0;
         have_left_d = 1'b0;
      end else if (input_word_clock != prev_wclk_q) begin
         // half frame closes; pick source and length per framing
         case (fr)
            FR_I2S: begin
               // the bit under the edge is still the old lsb
               wsrc = shift_en ? sh : sr_q;
               n = shift_en ? cnt_q + 5'h01 : cnt_q;
            end
            FR_RJ: begin
               n = rj_len(lfmt_q);
            end
            default: begin
               n = cnt_q;
            end
         endcase
         word = wsrc << (WORD_MAX - n);
         // i2s has left while low, the justified modes while high
         left_half = (fr == FR_I2S) ? !prev_wclk_q : prev_wclk_q;
         if (left_half) begin
            left_d = word;
            have_left_d = 1'b1;
         end else if (have_left_q) begin
            frame_d = '{left: left_q, right: word};
            tog_d = ~tog_q;
            have_left_d = 1'b0;
         end
         // start the next half
         if (fr == FR_LJ) begin
            sr_d = {23'h000000, serial_audio_in};
            cnt_d = 5'h01;
         end else if (fr == FR_RJ) begin
            sr_d = sh;
            cnt_d = 5'h01;
         end else begin
            sr_d = '0;
            cnt_d = '0;
         end
      end else if (shift_en) begin
         sr_d = sh;
         cnt_d = (cnt_q < WORD_MAX) ? cnt_q + 5'h01 : cnt_q;
      end
   end

   // deserialiser registers
   always_ff @(posedge input_bit_clock) begin
      prev_wclk_q <= input_word_clock;
      if (lrst_q) begin
         sr_q <= '0;
         cnt_q <= '0;
         left_q <= '0;
         have_left_q <= 1'b0;
         frame_q <= '0;
         tog_q <= 1'b0;
      end else begin
         sr_q <= sr_d;
         cnt_q <= cnt_d;
         left_q <= left_d;
         have_left_q <= have_left_d;
         frame_q <= frame_d;
         tog_q <= tog_d;
      end
   end

   // -------------------------------------------------------------
   // crossing: toggle into core, pair taken from a stable register
   // -------------------------------------------------------------
   // frame_q stays put for a whole frame after the toggle, far
   // longer than the three core cycles the crossing needs
   assign new_frame = tog_s2_q ^ tog_s3_q;

   always_comb begin
      hold_d = hold_q;
      hold_word_d = hold_word_q;
      overrun_d = overrun_q;
      case (hold_q)
         H_IDLE: begin
            if (new_frame) begin
               hold_word_d = '{bypass: strap_q.bypass, pair: frame_q};
               hold_d = H_FULL;
            end
         end
         H_FULL: begin
            if (fifo_in_ready) begin
               hold_d = H_IDLE;
            end
            if (new_frame) begin
               if (fifo_in_ready) begin
                  hold_word_d = '{bypass: strap_q.bypass, pair: frame_q};
                  hold_d = H_FULL;
               end else begin
                  // fifo and holding register full: newest pair lost
                  overrun_d = 1'b1;
               end
            end
         end
         default: begin
            hold_d = H_IDLE;
         end
      endcase
   end

   // crossing registers; first sync stage read by the second only
   always_ff @(posedge core_clk) begin
      tog_s1_q <= tog_q;
      if (rst) begin
         tog_s2_q <= 1'b0;
         tog_s3_q <= 1'b0;
         hold_q <= H_IDLE;
         hold_word_q <= '0;
         overrun_q <= 1'b0;
      end else begin
         tog_s2_q <= tog_s1_q;
         tog_s3_q <= tog_s2_q;
         hold_q <= hold_d;
         hold_word_q <= hold_word_d;
         overrun_q <= overrun_d;
      end
   end

   // -------------------------------------------------------------
   // pair buffer; a stalled consumer backs up into the holder
   // -------------------------------------------------------------
   audio_in_fifo #(
      .W($bits(rx_word_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .core_clk(core_clk),
      .rst(rst),
      .in_valid(hold_q == H_FULL),
      .in_ready(fifo_in_ready),
      .in_data(hold_word_q),
      .out_valid(fifo_out_valid),
      .out_ready(pair_ready),
      .out_data(fifo_out)
   );

   // -------------------------------------------------------------
   // output stage: one-cycle strobe per pair, routed by bypass tag
   // -------------------------------------------------------------
   always_comb begin
      fire = fifo_out_valid & pair_ready;
      pair_d = fire ? fifo_out.pair : pair_q;
      conv_valid_d = fire & ~fifo_out.bypass;
      bypass_valid_d = fire & fifo_out.bypass;
   end

   // output registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pair_q <= '0;
         conv_valid_q <= 1'b0;
         bypass_valid_q <= 1'b0;
      end else begin
         pair_q <= pair_d;
         conv_valid_q <= conv_valid_d;
         bypass_valid_q <= bypass_valid_d;
      end
   end

   assign pair_data = pair_q;
   assign conv_valid = conv_valid_q;
   assign bypass_valid = bypass_valid_q;
   assign master_conflict = conflict_q;
   assign format_unused = unused_q;
   assign overrun = overrun_q;

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   strobe_cause_a: assert property (@(posedge core_clk) disable iff (rst)
      (conv_valid_q || bypass_valid_q) |-> $past(pair_ready))
      else $error("pair strobe without consumer ready");

   route_excl_a: assert property (@(posedge core_clk) disable iff (rst)
      !(conv_valid_q && bypass_valid_q))
      else $error("pair sent both to converter and bypass");

   single_master_a: assert property (@(posedge core_clk) disable iff (rst)
      strap_q.out_master ##1 strap_q.out_master |-> !in_master_q)
      else $error("input port master while output port master");

   hold_drain_a: assert property (@(posedge core_clk) disable iff (rst)
      hold_q == H_FULL && fifo_in_ready && !new_frame |=> hold_q == H_IDLE)
      else $error("held pair not moved into fifo");

   // core reset also masks the first bit clock edges, before lrst_q is known
   bad_fmt_quiet_a: assert property (@(posedge input_bit_clock)
      disable iff (rst || lrst_q) fr == FR_BAD |=> tog_q == $past(tog_q))
      else $error("pair emitted under unused format code");

   count_cap_a: assert property (@(posedge input_bit_clock)
      disable iff (rst || lrst_q) cnt_q <= WORD_MAX)
      else $error("bit count ran past word width");
endmodule

// >>> dv/audio_src_model.sv
// partner model: serial audio source driving bit clock, word clock and data
// assumes: device port in slave mode; clocks stand still between bursts
`timescale 1ns/10ps
module audio_src_model
   import audio_in_pkg::*;
(
   output logic bit_clock,
   output logic word_clock,
   output logic sdata
);
   // ---------------------------------
   // serial source
   // ---------------------------------
   initial begin
      bit_clock = 1'b0;
      word_clock = 1'b0;
      sdata = 1'b0;
   end
   // one bit: lines change after the falling edge, 15 ns bit clock
   task automatic put(input logic wc, input logic d);
      word_clock = wc;
      sdata = d;
      #7.5 bit_clock = 1'b1;
      #7.5 bit_clock = 1'b0;
   endtask
   // bit k of a 32-clock half, msb first as the framing places it
   function automatic logic pick(input logic [2:0] f, input logic [23:0] w,
                                 input int k);
      int n;
      n = (f == FMT_RJ16) ? 16 : (f == FMT_RJ18) ? 18 : (f == FMT_RJ20) ? 20 : 24;
      if (f == FMT_LJ24) return (k < 24) ? w[23-k] : 1'b0;
      if (f == FMT_I2S24) return (k >= 1 && k <= 24) ? w[24-k] : 1'b0;
      return (k >= 32 - n) ? w[55-n-k] : 1'b0;
   endfunction
   // n frames of l+i / r+i, led by a spare right half, closed by one edge
   task automatic send(input logic [2:0] f, input logic [23:0] l, input logic [23:0] r,
                       input int n);
      logic lv;
      lv = (f != FMT_I2S24); // left on high word clock, low for i2s
      for (int k = 0; k < 32; k++) put(!lv, 1'b0);
      for (int i = 0; i < n; i++) begin
         for (int k = 0; k < 32; k++) put(lv, pick(f, l + 24'(i), k));
         for (int k = 0; k < 32; k++) put(!lv, pick(f, r + 24'(i), k));
      end
      put(lv, 1'b0);
      sdata = ~sdata; // released line must not keep showing the last bit
   endtask
endmodule

// >>> dv/testbench.sv
// testbench for the audio input serial port
// assumes: source model on the link, pins resolved from output enables
`timescale 1ns/10ps
module testbench
   import audio_in_pkg::*;
;
   logic core_clk, reference_clock_in, rst, bypass_sel, pair_ready;
   logic input_master_sel, output_master_sel;
   logic [2:0] input_format_select;
   logic bclk_o, bclk_oe, wclk_o, wclk_oe, src_bclk, src_wclk, serial_audio_in;
   logic conv_valid, bypass_valid, master_conflict, format_unused, overrun;
   stereo_pair_t pair_data;
   wire bclk_pin = bclk_oe ? bclk_o : src_bclk; // pin level from both parties
   wire wclk_pin = wclk_oe ? wclk_o : src_wclk;
   int error_cnt = 0;
   int n_compared = 0;
   audio_input_serial_port u_audio_input_serial_port (.core_clk, .rst,
      .input_bit_clock(bclk_pin), .input_bit_clock_o(bclk_o), .input_bit_clock_oe(bclk_oe),
      .input_word_clock(wclk_pin), .input_word_clock_o(wclk_o),
      .input_word_clock_oe(wclk_oe), .serial_audio_in, .reference_clock_in,
      .input_format_select, .input_master_sel, .output_master_sel, .bypass_sel,
      .pair_ready, .pair_data, .conv_valid, .bypass_valid, .master_conflict,
      .format_unused, .overrun);
   audio_src_model src (.bit_clock(src_bclk), .word_clock(src_wclk), .sdata(serial_audio_in));
   // ---------------------------------
   // clocks and helpers
   // ---------------------------------
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   initial begin
      reference_clock_in = 1'b0;
      forever #10 reference_clock_in = ~reference_clock_in;
   end
   task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("mismatches %0d comparisons %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // bounded wait for a strobe: 1 converter, 2 bypass, 0 none
   task automatic strobe(output logic [1:0] got);
      got = 2'h0;
      for (int i = 0; i < 300 && got == 2'h0; i++) begin
         @(negedge core_clk);
         got = {bypass_valid, conv_valid};
      end
   endtask
   // right-justified words come out msb aligned, zeros below
   function automatic logic [23:0] algn(input logic [2:0] f, input logic [23:0] w);
      int n;
      n = (f == FMT_RJ16) ? 16 : (f == FMT_RJ18) ? 18 : (f == FMT_RJ20) ? 20 : 24;
      return w & (24'hffffff << (24 - n));
   endfunction
   // ---------------------------------
   // scenarios
   // ---------------------------------
   task automatic t_formats();
      // i2s between same-polarity codes: a send opening on the right level
      // would close a stray one-bit left half and deliver an extra pair
      logic [2:0] codes [10] = '{3'h0, 3'h1, 3'h4, 3'h1, 3'h5, 3'h1, 3'h6, 3'h1, 3'h7, 3'h1};
      logic [1:0] got;
      foreach (codes[j]) begin
         input_format_select = codes[j];
         repeat (4) @(negedge core_clk);
         src.send(codes[j], 24'h9a5c3f, 24'h65a3c1, 1);
         strobe(got);
         chk("conv strobe", 48'(got), 48'h1);
         chk("pair", pair_data, {algn(codes[j], 24'h9a5c3f), algn(codes[j], 24'h65a3c1)});
         @(negedge core_clk);
         chk("strobe width", 48'(conv_valid), 48'h0);
      end
   endtask
   task automatic t_bypass();
      logic [1:0] got;
      bypass_sel = 1'b1;
      input_format_select = FMT_LJ24;
      repeat (4) @(negedge core_clk);
      src.send(FMT_LJ24, 24'h123456, 24'hfedcba, 1);
      strobe(got);
      chk("bypass strobe", 48'(got), 48'h2);
      chk("bypass pair", pair_data, {24'h123456, 24'hfedcba});
      bypass_sel = 1'b0;
   endtask
   task automatic t_unused();
      logic [1:0] got;
      for (int c = 2; c < 4; c++) begin
         input_format_select = 3'(c);
         repeat (4) @(negedge core_clk);
         chk("format unused", 48'(format_unused), 48'h1);
         src.send(3'(c), 24'h111111, 24'h222222, 1);
         strobe(got);
         chk("no capture", 48'(got), 48'h0);
      end
   endtask
   // consumer stalls: 4 in fifo plus holder kept, sixth pair dropped
   task automatic t_overrun();
      logic [1:0] got;
      input_format_select = FMT_LJ24;
      pair_ready = 1'b0;
      repeat (4) @(negedge core_clk);
      chk("overrun idle", 48'(overrun), 48'h0);
      src.send(FMT_LJ24, 24'h000100, 24'h800100, 6);
      repeat (20) @(negedge core_clk);
      chk("overrun", 48'(overrun), 48'h1);
      pair_ready = 1'b1;
      for (int i = 0; i < 5; i++) begin
         strobe(got);
         chk("drain pair", pair_data, {24'h000100 + 24'(i), 24'h800100 + 24'(i)});
      end
   endtask
   task automatic t_master();
      int run, nt;
      int lens [2];
      logic prev;
      input_master_sel = 1'b1;
      output_master_sel = 1'b1;
      repeat (8) @(negedge core_clk);
      chk("conflict", 48'({master_conflict, bclk_oe}), 48'h2);
      output_master_sel = 1'b0;
      repeat (8) @(negedge core_clk);
      chk("master drive", 48'({master_conflict, bclk_oe, wclk_oe}), 48'h3);
      lens = '{0, 0};
      run = 0;
      nt = 0;
      prev = wclk_pin;
      // bit clocks per word clock level, over one whole period
      for (int i = 0; i < 300 && nt < 3; i++) begin
         @(posedge bclk_pin);
         if (wclk_pin !== prev) begin
            if (nt > 0) lens[nt-1] = run;
            nt++;
            run = 0;
            prev = wclk_pin;
         end
         run++;
      end
      chk("bclk per frame", 48'(lens[0] + lens[1]), 48'h40);
      chk("word clock duty", 48'(lens[0]), 48'h20);
      input_master_sel = 1'b0;
   endtask
   // ---------------------------------
   // main sequence and watchdog
   // ---------------------------------
   initial begin
      rst = 1'b1;
      bypass_sel = 1'b0;
      pair_ready = 1'b1;
      input_master_sel = 1'b0;
      output_master_sel = 1'b0;
      input_format_select = 3'h0;
      fork
         src.send(FMT_LJ24, 24'h0, 24'h0, 0); // bit clock edges during reset
         repeat (16) @(negedge core_clk);
      join
      rst = 1'b0;
      repeat (8) @(negedge core_clk);
      t_formats();
      t_bypass();
      t_unused();
      t_overrun();
      t_master();
      tally_and_finish();
   end
   initial begin
      #2ms;
      error_cnt++;
      tally_and_finish();
   end
endmodule
